/* core/pcr_line_sync.sv */
// Synchroniser for the PS/2 clock and data pins, with a falling-edge finder on the clock pin only
`timescale 1ns/100ps

module pcr_line_sync
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire pcr_pkg::pcr_lines_s pins,
  output pcr_pkg::pcr_lines_s     lines,
  output logic                    clk_fall
);

  // ==========================================================
  // Two-stage synchroniser
  pcr_pkg::pcr_lines_s meta_r;
  pcr_pkg::pcr_lines_s sync_r;
  logic                clk_prev_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_r     <= 2'b11;
      sync_r     <= 2'b11;
      clk_prev_r <= 1'b1;
    end
    else
    begin
      meta_r     <= pins;
      sync_r     <= meta_r;
      clk_prev_r <= sync_r.clk;
    end
  end

  // ==========================================================
  // Edge seen only on the settled stage
  assign lines    = sync_r;
  assign clk_fall = clk_prev_r & ~sync_r.clk;

endmodule

/* core/pcr_top.sv */
// PS/2 channel receiver with AHB-Lite register slave and interrupt
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps

// Functional notes
// - Enabled receive mode floats data, and floats clock unless a byte is held
// - Disabled channel drives lines from manual bits
// - Eleventh falling edge completes frame, ready
// - Receive data read clears ready flag
// - Receive data read releases clock line
// - Ready flag raises interrupt quickly
// - Interrupt pends until source register read or write-one clear
module pcr_top
#(
  parameter int GAP_CYC = pcr_pkg::GAP_CYC_DEF
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  input  wire logic        ps2_clk_in,
  output logic             ps2_clk_out,
  output logic             ps2_clk_oe,
  input  wire logic        ps2_data_in,
  output logic             ps2_data_out,
  output logic             ps2_data_oe
);

  localparam logic [pcr_pkg::GAP_W-1:0] GAP_LIM =
    pcr_pkg::GAP_W'(GAP_CYC - 1);

  // ==========================================================
  // State
  pcr_pkg::pcr_ctrl_s            ctrl_r;
  logic [pcr_pkg::INT_W-1:0]     int_stat_r;
  logic [pcr_pkg::INT_W-1:0]     int_mask_r;
  logic [7:0]                    rx_data_r;
  logic                          ready_r;
  logic                          perr_r;
  logic                          ferr_r;
  logic                          hold_r;
  logic [3:0]                    bit_cnt_r;
  logic [10:0]                   shift_r;
  logic [pcr_pkg::GAP_W-1:0]     gap_cnt_r;
  logic                          dp_valid_r;
  logic                          dp_write_r;
  logic [31:0]                   dp_addr_r;
  logic [31:0]                   hrdata_r;
  logic                          irq_r;
  logic                          clk_out_r;
  logic                          clk_oe_r;
  logic                          data_out_r;
  logic                          data_oe_r;

  // ==========================================================
  // Pin sampling
  pcr_pkg::pcr_lines_s pins;
  pcr_pkg::pcr_lines_s lines;
  logic                clk_fall;

  assign pins.clk  = ps2_clk_in;
  assign pins.data = ps2_data_in;

  pcr_line_sync u_sync
  (
    .core_clk (core_clk),
    .rst      (rst),
    .pins     (pins),
    .lines    (lines),
    .clk_fall (clk_fall)
  );

  // ==========================================================
  // Bus decode
  logic ap_take;
  logic ap_read;
  logic rx_rd;
  logic int_rd;
  logic dp_wr;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  assign ap_take = hsel & hready & htrans[1];
  assign ap_read = ap_take & ~hwrite;
  // Side effects fire at the taken edge, same edge that latches hrdata
  assign rx_rd   = ap_read & (haddr == pcr_pkg::RXDATA_OFS);
  assign int_rd  = ap_read & (haddr == pcr_pkg::INT_STAT_OFS);
  assign dp_wr   = dp_valid_r & dp_write_r;
  assign wr_ctrl = dp_wr & (dp_addr_r == pcr_pkg::CTRL_OFS);
  assign wr_stat = dp_wr & (dp_addr_r == pcr_pkg::INT_STAT_OFS);
  assign wr_mask = dp_wr & (dp_addr_r == pcr_pkg::INT_MASK_OFS);

  // ==========================================================
  // Read mux
  logic [31:0] status_word;
  logic [31:0] rd_nxt;

  assign status_word = {26'h000_0000, (bit_cnt_r != 4'h0), lines.data,
                        lines.clk, ferr_r, perr_r, ready_r};

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (haddr)
      pcr_pkg::CTRL_OFS:     rd_nxt = {28'h000_0000, ctrl_r};
      pcr_pkg::STATUS_OFS:   rd_nxt = status_word;
      pcr_pkg::RXDATA_OFS:   rd_nxt = {24'h00_0000, rx_data_r};
      pcr_pkg::INT_STAT_OFS: rd_nxt = {29'h0000_0000, int_stat_r};
      pcr_pkg::INT_MASK_OFS: rd_nxt = {29'h0000_0000, int_mask_r};
      default:               rd_nxt = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Frame receiver
  logic        rx_on;
  logic        shift_en;
  logic        frame_done;
  logic        gap_out;
  logic [10:0] frame;
  logic        start_bad;
  logic        stop_bad;
  logic        par_bad;
  logic        frame_err;

  assign rx_on      = ctrl_r.channel_enable & ~ctrl_r.direction_select
                    & ~hold_r;
  assign shift_en   = rx_on & clk_fall;
  assign frame_done = shift_en & (bit_cnt_r == pcr_pkg::LAST_BIT);
  // Bits arrive LSB first, so shift in at the top
  assign frame      = {lines.data, shift_r[10:1]};
  assign start_bad  = frame[0];
  assign stop_bad   = ~frame[10];
  assign par_bad    = ~(^frame[9:1]);
  assign frame_err  = frame_done & (start_bad | stop_bad | par_bad);
  // A silent peripheral mid-frame must not wedge the bit counter
  assign gap_out    = (bit_cnt_r != 4'h0) & (gap_cnt_r == GAP_LIM);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 11'h7FF;
      gap_cnt_r <= '0;
    end
    else if (!rx_on || gap_out || frame_done)
    begin
      bit_cnt_r <= 4'h0;
      shift_r   <= shift_en ? frame : shift_r;
      gap_cnt_r <= '0;
    end
    else if (shift_en)
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r   <= frame;
      gap_cnt_r <= '0;
    end
    else if (bit_cnt_r != 4'h0)
    begin
      gap_cnt_r <= gap_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Ready, hold and received byte
  logic ready_nxt;
  logic hold_nxt;

  // Completion wins over a read clearing in the same cycle
  assign ready_nxt = frame_done | (ready_r & ~rx_rd);
  assign hold_nxt  = frame_done | (hold_r & ~rx_rd);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ready_r   <= 1'b0;
      hold_r    <= 1'b0;
      rx_data_r <= 8'h00;
      perr_r    <= 1'b0;
      ferr_r    <= 1'b0;
    end
    else
    begin
      ready_r <= ready_nxt;
      hold_r  <= hold_nxt;
      if (frame_done)
      begin
        rx_data_r <= frame[8:1];
        perr_r    <= par_bad;
        ferr_r    <= start_bad | stop_bad;
      end
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [pcr_pkg::INT_W-1:0] int_set;
  logic [pcr_pkg::INT_W-1:0] int_clr;
  logic [pcr_pkg::INT_W-1:0] int_nxt;

  assign int_set = {~ctrl_r.channel_enable & clk_fall, frame_err,
                    frame_done};
  // Reading the source register acks everything; write-one also clears
  assign int_clr = (wr_stat ? hwdata[pcr_pkg::INT_W-1:0] : 3'h0)
                 | {pcr_pkg::INT_W{int_rd}};
  assign int_nxt = (int_stat_r & ~int_clr) | int_set;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      int_stat_r <= 3'h0;
      int_mask_r <= pcr_pkg::INT_MASK_RST;
      irq_r      <= 1'b0;
    end
    else
    begin
      int_stat_r <= int_nxt;
      irq_r      <= |(int_stat_r & int_mask_r);
      if (wr_mask)
        int_mask_r <= hwdata[pcr_pkg::INT_W-1:0];
    end
  end

  // ==========================================================
  // Control register and bus phase
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_r     <= pcr_pkg::CTRL_RST;
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= 32'h0000_0000;
      hrdata_r   <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= hwdata[3:0];
      if (hready)
      begin
        dp_valid_r <= ap_take;
        dp_write_r <= hwrite;
        dp_addr_r  <= haddr;
      end
      if (ap_read)
        hrdata_r <= rd_nxt;
    end
  end

  // ==========================================================
  // Line drivers
  logic clk_oe_nxt;
  logic clk_out_nxt;
  logic data_oe_nxt;
  logic data_out_nxt;
  logic en;

  assign en           = ctrl_r.channel_enable;
  // Transmit direction pulls clock low; transmit itself lives elsewhere
  assign clk_oe_nxt   = ~en | ctrl_r.direction_select
                      | hold_nxt;
  assign clk_out_nxt  = ~en & ctrl_r.manual_clk;
  assign data_oe_nxt  = ~en;
  assign data_out_nxt = ~en & ctrl_r.manual_data;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clk_oe_r   <= 1'b0;
      clk_out_r  <= 1'b0;
      data_oe_r  <= 1'b0;
      data_out_r <= 1'b0;
    end
    else
    begin
      clk_oe_r   <= clk_oe_nxt;
      clk_out_r  <= clk_out_nxt;
      data_oe_r  <= data_oe_nxt;
      data_out_r <= data_out_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata       = hrdata_r;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign irq          = irq_r;
  assign ps2_clk_out  = clk_out_r;
  assign ps2_clk_oe   = clk_oe_r;
  assign ps2_data_out = data_out_r;
  assign ps2_data_oe  = data_oe_r;

  // ==========================================================
  // Checks
  a_rx_float: assert property (@(posedge core_clk) disable iff (rst)
    (en && !ctrl_r.direction_select && !hold_nxt)
      |=> (!ps2_clk_oe && !ps2_data_oe))
    else $error("receive mode did not float the lines");

  a_manual_drive: assert property (@(posedge core_clk) disable iff (rst)
    !en |=> (ps2_clk_oe && ps2_data_oe
             && ps2_clk_out == $past(ctrl_r.manual_clk)
             && ps2_data_out == $past(ctrl_r.manual_data)))
    else $error("manual levels not driven");

  a_frame_ready: assert property (@(posedge core_clk) disable iff (rst)
    (shift_en && bit_cnt_r == 4'hA) |=> (ready_r && hold_r))
    else $error("eleventh edge did not set ready");

  a_no_early: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ready_r) |-> $past(shift_en) && $past(bit_cnt_r) == 4'hA)
    else $error("ready rose without a full frame");

  a_read_clear: assert property (@(posedge core_clk) disable iff (rst)
    (rx_rd && !frame_done) ##1 !frame_done |-> !ready_r ##1 !ready_r)
    else $error("receive read left ready set");

  a_clk_release: assert property (@(posedge core_clk) disable iff (rst)
    (rx_rd && en && !ctrl_r.direction_select && !frame_done)
      |-> ##[1:5] !ps2_clk_oe)
    else $error("clock not released after read");

  a_irq_raise: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(ready_r) && int_mask_r[0]) |-> ##[1:5] irq)
    else $error("interrupt not raised after ready");

  a_irq_pend: assert property (@(posedge core_clk) disable iff (rst)
    (int_stat_r[0] && !int_rd && !wr_stat) |=> int_stat_r[0])
    else $error("pending interrupt dropped without ack");

  a_irq_ack: assert property (@(posedge core_clk) disable iff (rst)
    (int_rd && int_set == 3'h0) |=> int_stat_r == 3'h0)
    else $error("source read did not clear interrupt");

  a_hold_low: assert property (@(posedge core_clk) disable iff (rst)
    (hold_r && !rx_rd && en) |=> (ps2_clk_oe && !ps2_clk_out))
    else $error("clock not held low while byte waits");

  a_lsb_first: assert property (@(posedge core_clk) disable iff (rst)
    (frame_done && !start_bad && !stop_bad)
      |=> rx_data_r == $past(shift_r[9:2]))
    else $error("data bits not assembled lsb first");

endmodule

/* shared/pcr_pkg.sv */
// Constants, register map and carrier types for the PS/2 receive channel
package pcr_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [31:0] CTRL_OFS     = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS   = 32'h0000_0004;
  localparam logic [31:0] RXDATA_OFS   = 32'h0000_0008;
  localparam logic [31:0] INT_STAT_OFS = 32'h0000_000C;
  localparam logic [31:0] INT_MASK_OFS = 32'h0000_0010;

  // ==========================================================
  // Field positions
  localparam int ST_READY   = 0;
  localparam int ST_PERR    = 1;
  localparam int ST_FERR    = 2;
  localparam int ST_CLK_LVL = 3;
  localparam int ST_DAT_LVL = 4;
  localparam int ST_BUSY    = 5;
  localparam int INT_W      = 3;
  localparam int INT_RX     = 0;
  localparam int INT_ERR    = 1;
  localparam int INT_BANG   = 2;

  // ==========================================================
  // Reset values
  localparam logic [3:0]       CTRL_RST     = 4'hC;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  // ==========================================================
  // Frame and timing
  localparam logic [3:0] LAST_BIT      = 4'hA;
  localparam int         CLK_PERIOD_NS = 20;
  localparam int         T_LINE_NS     = 100;
  localparam int         LINE_CYC      = T_LINE_NS / CLK_PERIOD_NS;
  localparam int         T_RDY_NS      = 1600;
  localparam int         RDY_CYC       = T_RDY_NS / CLK_PERIOD_NS;
  localparam int         T_GAP_NS      = 302000;
  localparam int         GAP_CYC_DEF   = T_GAP_NS / CLK_PERIOD_NS;
  localparam int         GAP_W         = 14;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic manual_data;
    logic manual_clk;
    logic direction_select;
    logic channel_enable;
  } pcr_ctrl_s;

  typedef struct packed {
    logic clk;
    logic data;
  } pcr_lines_s;

endpackage

/* tb/pcr_ps2_dev.sv */
// Behavioural PS/2 peripheral that sends frames to the receive channel
`timescale 1ns/100ps

module pcr_ps2_dev
(
  input  wire logic clk_wire,
  output logic      clk_pull,
  output logic      dat_pull
);
  // ==========================================================
  // Open drain: 1 releases the line to its pull-up
  initial
  begin
    clk_pull = 1'b1;
    dat_pull = 1'b1;
  end

  // ==========================================================
  // Frame sender
  // Phases scaled far below the real minimum to keep the run short
  task automatic send(input logic [7:0] b, input logic bad, input int half);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    // Host holding the clock low inhibits the frame
    while (clk_wire !== 1'b1)
      #10;
    for (int i = 0; i < 11; i++)
    begin
      dat_pull = f[i];
      #(half);
      clk_pull = 1'b0;
      #(half);
      clk_pull = 1'b1;
    end
    dat_pull = 1'b1;
  endtask

  // Lone clock fall, for bit-bang mode
  task automatic pulse(input int half);
    clk_pull = 1'b0;
    #(half);
    clk_pull = 1'b1;
  endtask
endmodule

/* tb/tb_top.sv */
// Register-level testbench for the PS/2 receive channel
`timescale 1ns/100ps

module tb_top;
  logic        core_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        clk_out;
  logic        clk_oe;
  logic        dat_out;
  logic        dat_oe;
  logic        clk_pull;
  logic        dat_pull;
  logic        clk_wire;
  logic        dat_wire;
  logic [31:0] rd;
  int          err_count;
  int          num_checks;
  int          cyc;

  // ==========================================================
  // Wired lines: pull-up, either side may pull low
  assign clk_wire = clk_pull & (clk_oe ? clk_out : 1'b1);
  assign dat_wire = dat_pull & (dat_oe ? dat_out : 1'b1);

  pcr_top #(.GAP_CYC(200)) pcr_top_i
  (
    .core_clk     (core_clk),
    .rst          (rst),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .irq          (irq),
    .ps2_clk_in   (clk_wire),
    .ps2_clk_out  (clk_out),
    .ps2_clk_oe   (clk_oe),
    .ps2_data_in  (dat_wire),
    .ps2_data_out (dat_out),
    .ps2_data_oe  (dat_oe)
  );

  pcr_ps2_dev pcr_ps2_dev_i
  (
    .clk_wire (clk_wire),
    .clk_pull (clk_pull),
    .dat_pull (dat_pull)
  );

  initial
  begin
    core_clk = 1'b0;
  end

  always #10 core_clk = ~core_clk;

  // ==========================================================
  // Report and bus tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk("resp", hresp, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task automatic frame(input logic [7:0] b, input logic bad, input int half,
                       input logic en);
    int n;
    xfer(1'b1, pcr_pkg::INT_MASK_OFS, en ? 32'h0000_0007 : 32'h0000_0000);
    pcr_ps2_dev_i.send(b, bad, half);
    // Send returns one phase after the last fall
    for (n = 0; n < pcr_pkg::RDY_CYC && clk_oe !== 1'b1; n++)
      @(posedge core_clk);
    chk("hold", {clk_oe, clk_out, clk_wire}, 3'h4);
    repeat (2) @(posedge core_clk);
    chk("irq", irq, en);
    rdc("status", pcr_pkg::STATUS_OFS, 32'h0000_0011 | (bad << 1));
    rdc("rxdata", pcr_pkg::RXDATA_OFS, {24'h00_0000, b});
    repeat (pcr_pkg::LINE_CYC) @(posedge core_clk);
    chk("release", clk_oe, 1'b0);
    // Parity error stays until the next completed frame
    rdc("status", pcr_pkg::STATUS_OFS, 32'h0000_0018 | (bad << 1));
    chk("irq pend", irq, en);
    rdc("int", pcr_pkg::INT_STAT_OFS, 32'h0000_0001 | (bad << 1));
    repeat (2) @(posedge core_clk);
    chk("irq clr", irq, 1'b0);
    $display("test frame %h done", b);
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst        = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h0000_0000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0000_0000;
    err_count  = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdc("ctrl", pcr_pkg::CTRL_OFS, {28'h000_0000, pcr_pkg::CTRL_RST});
    rdc("mask", pcr_pkg::INT_MASK_OFS, 32'h0000_0000);
    rdc("unmapped", 32'h0000_0020, 32'h0000_0000);
    for (int v = 0; v < 4; v++)
    begin
      xfer(1'b1, pcr_pkg::CTRL_OFS, v << 2);
      repeat (pcr_pkg::LINE_CYC) @(posedge core_clk);
      chk("manual", {clk_oe, clk_out, dat_oe, dat_out},
          {1'b1, v[0], 1'b1, v[1]});
    end
    // Manual clock low above counts as a bit-bang fall
    xfer(1'b1, pcr_pkg::INT_STAT_OFS, 32'h0000_0007);
    rdc("int wclr", pcr_pkg::INT_STAT_OFS, 32'h0000_0000);
    xfer(1'b1, pcr_pkg::INT_MASK_OFS, 32'h0000_0004);
    pcr_ps2_dev_i.pulse(200);
    repeat (4) @(posedge core_clk);
    chk("bang irq", irq, 1'b1);
    rdc("bang int", pcr_pkg::INT_STAT_OFS, 32'h0000_0004);
    $display("test manual done");
    xfer(1'b1, pcr_pkg::CTRL_OFS, 32'h0000_0003);
    repeat (pcr_pkg::LINE_CYC) @(posedge core_clk);
    chk("transmit", {clk_oe, clk_out, dat_oe}, 3'h4);
    xfer(1'b1, pcr_pkg::CTRL_OFS, 32'h0000_0001);
    repeat (pcr_pkg::LINE_CYC) @(posedge core_clk);
    chk("float", {clk_oe, dat_oe}, 2'h0);
    // Lone fall starts a frame that the gap limit must drop
    pcr_ps2_dev_i.pulse(80);
    repeat (pcr_pkg::LINE_CYC) @(posedge core_clk);
    rdc("busy", pcr_pkg::STATUS_OFS, 32'h0000_0038);
    repeat (210) @(posedge core_clk);
    rdc("dropped", pcr_pkg::STATUS_OFS, 32'h0000_0018);
    $display("test gap done");
    frame(8'hA5, 1'b0, 80, 1'b1);
    frame(8'h3C, 1'b1, 80, 1'b1);
    frame(8'h80, 1'b0, 80, 1'b0);
    end_sim();
  end
endmodule
